// *** rtl/stepper_pkg.sv ***
package stepper_pkg;

    localparam int CLK_HZ = 20000000;
    localparam int PWM_HZ = 25000;
    localparam int PWM_PERIOD_CYCLES = CLK_HZ / PWM_HZ;
    localparam int PWM_COUNT_WIDTH = 10;
    localparam int MIN_ON_CYCLES = 8;

    localparam int POS_WIDTH = 8;
    localparam logic [7:0] POS_RESET = 8'h00;
    localparam logic [7:0] FULL_STEP_START = 8'h20;
    localparam logic [7:0] QUADRANT_SIZE = 8'h40;
    localparam logic [7:0] HALF_STEP_SIZE = 8'h20;

    localparam logic [2:0] RES_1_64 = 3'h0;
    localparam logic [2:0] RES_1_32 = 3'h1;
    localparam logic [2:0] RES_1_16 = 3'h2;
    localparam logic [2:0] RES_1_8 = 3'h3;
    localparam logic [2:0] RES_1_4 = 3'h4;
    localparam logic [2:0] RES_HALF_COMP = 3'h5;
    localparam logic [2:0] RES_HALF_UNCOMP = 3'h6;
    localparam logic [2:0] RES_FULL = 3'h7;

    localparam logic [6:0] SETPOINT_MAX = 7'h64;
    localparam logic [6:0] DIAGONAL_LOW = 7'h47;

    // Gate timing: t1 450..2700 ns, t2 and toff 1250..5000 ns, dead time 250 ns..1 us
    localparam int T1_STEP_NS = 125;
    localparam int T2_STEP_NS = 250;
    localparam int TOFF_STEP_NS = 250;
    localparam int DEAD_STEP_NS = 250;
    localparam int CLK_PERIOD_NS = 1000000000 / CLK_HZ;
    localparam int T1_UNIT_CYCLES = (T1_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T2_UNIT_CYCLES = (T2_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TOFF_UNIT_CYCLES = (TOFF_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DEAD_UNIT_CYCLES = (DEAD_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TIMER_WIDTH = 8;

    typedef struct packed {
        logic [3:0] t1_select;
        logic [3:0] t2_select;
        logic [3:0] toff_select;
        logic [1:0] dead_time_select;
        logic [3:0] on_current_select;
        logic [3:0] off_current_select;
    } gate_config_type;

    typedef struct packed {
        logic current_source_on;
        logic current_source_off;
        logic gate_pull_up_switch;
        logic gate_pull_down_switch;
    } gate_drive_type;

    typedef struct packed {
        logic sign;
        logic [6:0] magnitude;
    } setpoint_type;

endpackage : stepper_pkg

// *** rtl/setpoint_table.sv ***
`timescale 1ns/1ps
`default_nettype none
module setpoint_table (
    input wire logic [7:0] position,
    input wire logic square_mode,
    output stepper_pkg::setpoint_type coil_x,
    output stepper_pkg::setpoint_type coil_y
);
    import stepper_pkg::*;

    logic [6:0] sine_lut [0:64];
    logic [5:0] offset;
    logic [1:0] quadrant;

    // Quarter-wave magnitudes, index 0..64 of a quadrant
    assign sine_lut = '{
        7'h00, 7'h03, 7'h05, 7'h08, 7'h0A, 7'h0D, 7'h0E, 7'h11,
        7'h13, 7'h16, 7'h19, 7'h1B, 7'h1E, 7'h20, 7'h23, 7'h25,
        7'h26, 7'h29, 7'h2B, 7'h2E, 7'h30, 7'h33, 7'h34, 7'h36,
        7'h38, 7'h3B, 7'h3C, 7'h3E, 7'h3F, 7'h43, 7'h44, 7'h46,
        7'h47, 7'h49, 7'h4B, 7'h4C, 7'h4E, 7'h4F, 7'h51, 7'h53,
        7'h54, 7'h56, 7'h57, 7'h57, 7'h59, 7'h5A, 7'h5A, 7'h5C,
        7'h5E, 7'h5E, 7'h5F, 7'h5F, 7'h61, 7'h61, 7'h61, 7'h62,
        7'h62, 7'h62, 7'h64, 7'h64, 7'h64, 7'h64, 7'h64, 7'h64,
        7'h64
    };

    assign offset = position[5:0];
    assign quadrant = position[7:6];

    always_comb begin
        logic [6:0] mag_x;
        logic [6:0] mag_y;
        mag_x = sine_lut[offset];
        mag_y = sine_lut[7'd64 - {1'b0, offset}];
        if (offset == 6'h20 && square_mode) begin
            mag_x = SETPOINT_MAX;
            mag_y = SETPOINT_MAX;
        end
        // Odd quadrants swap roles; sign per quadrant
        coil_x.magnitude = quadrant[0] ? mag_y : mag_x;
        coil_y.magnitude = quadrant[0] ? mag_x : mag_y;
        coil_x.sign = quadrant[1] && (coil_x.magnitude != 7'h00);
        coil_y.sign = (quadrant == 2'h1 || quadrant == 2'h2) && (coil_y.magnitude != 7'h00);
    end
endmodule : setpoint_table
`default_nettype wire

// *** rtl/gate_sequencer.sv ***
`timescale 1ns/1ps
`default_nettype none
module gate_sequencer (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic high_request,
    input wire stepper_pkg::gate_config_type gate_config,
    output stepper_pkg::gate_drive_type high_drive,
    output stepper_pkg::gate_drive_type low_drive
);
    import stepper_pkg::*;

    typedef enum {IDLE_LOW, DEAD_TO_HIGH, HIGH_T1, HIGH_T2, HIGH_HOLD, HIGH_OFF,
        DEAD_TO_LOW, LOW_T1, LOW_T2, LOW_HOLD, LOW_OFF} seq_state_type;
    seq_state_type state;
    logic [TIMER_WIDTH-1:0] timer;
    logic [TIMER_WIDTH-1:0] t1_cycles;
    logic [TIMER_WIDTH-1:0] t2_cycles;
    logic [TIMER_WIDTH-1:0] toff_cycles;
    logic [TIMER_WIDTH-1:0] dead_cycles;

    // t1 from 450 ns, t2 and toff from 1250 ns, dead time 250 ns..1 us
    assign t1_cycles = TIMER_WIDTH'((3 + gate_config.t1_select) * T1_UNIT_CYCLES);
    assign t2_cycles = TIMER_WIDTH'((5 + gate_config.t2_select) * T2_UNIT_CYCLES);
    assign toff_cycles = TIMER_WIDTH'((5 + gate_config.toff_select) * TOFF_UNIT_CYCLES);
    assign dead_cycles = TIMER_WIDTH'((1 + gate_config.dead_time_select) * DEAD_UNIT_CYCLES);

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state <= LOW_HOLD;
            timer <= '0;
        end else begin
            if (timer != '0) begin
                timer <= timer - 1'b1;
            end
            case (state)
                LOW_HOLD: if (high_request) begin
                    state <= LOW_OFF;
                    timer <= toff_cycles;
                end
                LOW_OFF: if (timer == '0) begin
                    state <= DEAD_TO_HIGH;
                    timer <= dead_cycles;
                end
                DEAD_TO_HIGH: if (timer == '0) begin
                    state <= HIGH_T1;
                    timer <= t1_cycles;
                end
                HIGH_T1: if (timer == '0) begin
                    state <= HIGH_T2;
                    timer <= t2_cycles;
                end
                HIGH_T2: if (timer == '0) begin
                    state <= HIGH_HOLD;
                end
                HIGH_HOLD: if (!high_request) begin
                    state <= HIGH_OFF;
                    timer <= toff_cycles;
                end
                HIGH_OFF: if (timer == '0) begin
                    state <= DEAD_TO_LOW;
                    timer <= dead_cycles;
                end
                DEAD_TO_LOW: if (timer == '0) begin
                    state <= LOW_T1;
                    timer <= t1_cycles;
                end
                LOW_T1: if (timer == '0) begin
                    state <= LOW_T2;
                    timer <= t2_cycles;
                end
                LOW_T2: if (timer == '0) begin
                    state <= LOW_HOLD;
                end
                default: state <= LOW_HOLD;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            high_drive <= '{1'b0, 1'b0, 1'b0, 1'b1};
            low_drive <= '{1'b0, 1'b0, 1'b0, 1'b1};
        end else begin
            high_drive.current_source_on <= (state == HIGH_T1 || state == HIGH_T2);
            high_drive.current_source_off <= (state == HIGH_OFF);
            high_drive.gate_pull_up_switch <= (state == HIGH_HOLD);
            high_drive.gate_pull_down_switch <= !(state inside {HIGH_T1, HIGH_T2,
                HIGH_HOLD, HIGH_OFF});
            low_drive.current_source_on <= (state == LOW_T1 || state == LOW_T2);
            low_drive.current_source_off <= (state == LOW_OFF);
            low_drive.gate_pull_up_switch <= (state == LOW_HOLD);
            low_drive.gate_pull_down_switch <= !(state inside {LOW_T1, LOW_T2,
                LOW_HOLD, LOW_OFF});
        end
    end

    a_dead_gap: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !((high_drive.current_source_on || high_drive.gate_pull_up_switch)
        && (low_drive.current_source_on || low_drive.gate_pull_up_switch)))
        else $error("both transistors of half bridge driven on");
endmodule : gate_sequencer
`default_nettype wire

// *** rtl/microstep_translator_pwm.sv ***
`timescale 1ns/1ps
`default_nettype none
//Contract
// - Three-bit step_resolution_select picks one of eight resolutions, 1/64 to full.
// - Power-up or clear_pin resets translator position to zero.
// - At position zero, non-full modes command Y 100 percent, X zero.
// - Direction low, invert clear, enabled: steps increase position, except full step off a diagonal snaps to it.
// - Direction high or invert set: steps decrease position, except full step off a diagonal snaps to it.
// - Coarser modes use every second position of the next finer mode.
// - Uncompensated half and full step follow a square, others a circle.
// - Diagonal 100 percent only for resolution codes 11x, else 71 percent.
// - Positive setpoint means current from positive to negative coil terminal.
// - Sense comparator result is compared with setpoint continuously in regulation loop; code ignores it for the first 8 cycles of each PWM cycle.
// - Regulation loop PWM drives gate current sources and pull switches.
// - PWM switching points align to a fixed-frequency internal PWM clock.
// - PWM clock derives from the internal clock only, nominal 25 kHz.
// - pwm_jitter_enable adds jitter to PWM timing.
// - Switch-on applies source for t1 then t2; switch-off for off-time.
// - After on or off time, pull switch holds gate fully high or low.
// - Source magnitudes and phase durations are programmable configuration.
// - Programmable dead time from dead_time_select between half-bridge transistors.
// - Selected step edge moves one step; new current applies next PWM cycle.
// - position_readback reports position in 1/64 units always.
module microstep_translator_pwm #(
    parameter int PWM_PERIOD = stepper_pkg::PWM_PERIOD_CYCLES
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic step_pulse_pin,
    input wire logic direction_pin,
    input wire logic clear_pin,
    input wire logic sense_x_above,
    input wire logic sense_y_above,
    input wire logic [2:0] step_resolution_select,
    input wire logic drive_enable,
    input wire logic direction_invert_bit,
    input wire logic step_edge_polarity,
    input wire logic pwm_jitter_enable,
    input wire stepper_pkg::gate_config_type gate_config,
    output logic [7:0] position_readback,
    output stepper_pkg::setpoint_type coil_x_setpoint,
    output stepper_pkg::setpoint_type coil_y_setpoint,
    output logic pwm_cycle_start,
    output stepper_pkg::gate_drive_type [7:0] gate_drive,
    output logic [3:0] on_current_level,
    output logic [3:0] off_current_level
);
    import stepper_pkg::*;

    logic [2:0] step_sync;
    logic [1:0] dir_sync;
    logic [1:0] clear_sync;
    logic [1:0] sense_x_sync;
    logic [1:0] sense_y_sync;
    logic step_edge;
    logic step_up;
    logic [7:0] position;
    logic [7:0] next_position;
    logic [7:0] step_size;
    logic [PWM_COUNT_WIDTH-1:0] pwm_count;
    logic [PWM_COUNT_WIDTH-1:0] pwm_limit;
    logic [7:0] lfsr;
    logic pwm_tick;
    setpoint_type table_x;
    setpoint_type table_y;
    logic [1:0] coil_on;
    logic [3:0] bridge_request;
    logic [PWM_COUNT_WIDTH-1:0] on_count;

    // Pins are asynchronous to clk_sys
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            step_sync <= '0;
            dir_sync <= '0;
            clear_sync <= '0;
            sense_x_sync <= '0;
            sense_y_sync <= '0;
        end else begin
            step_sync <= {step_sync[1:0], step_pulse_pin};
            dir_sync <= {dir_sync[0], direction_pin};
            clear_sync <= {clear_sync[0], clear_pin};
            sense_x_sync <= {sense_x_sync[0], sense_x_above};
            sense_y_sync <= {sense_y_sync[0], sense_y_above};
        end
    end

    // Edge detect on second and third stages only
    assign step_edge = step_edge_polarity ? (step_sync[2] && !step_sync[1])
        : (!step_sync[2] && step_sync[1]);
    assign step_up = !dir_sync[1] && !direction_invert_bit;

    always_comb begin
        case (step_resolution_select)
            RES_1_64: step_size = 8'h01;
            RES_1_32: step_size = 8'h02;
            RES_1_16: step_size = 8'h04;
            RES_1_8: step_size = 8'h08;
            RES_1_4: step_size = 8'h10;
            RES_HALF_COMP: step_size = HALF_STEP_SIZE;
            RES_HALF_UNCOMP: step_size = HALF_STEP_SIZE;
            RES_FULL: step_size = QUADRANT_SIZE;
            default: step_size = 8'h01;
        endcase
    end

    always_comb begin
        next_position = step_up ? position + step_size : position - step_size;
        // Full step snaps onto a diagonal first
        if (step_resolution_select == RES_FULL && position[5:0] != 6'h20) begin
            next_position = {position[7:6], 6'h20};
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            position <= POS_RESET;
        end else if (clear_sync[1]) begin
            position <= POS_RESET;
        end else if (step_edge && drive_enable) begin
            position <= next_position;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            position_readback <= POS_RESET;
        end else begin
            position_readback <= position;
        end
    end

    setpoint_table u_table (
        .position(position),
        .square_mode(step_resolution_select[2:1] == 2'h3),
        .coil_x(table_x),
        .coil_y(table_y)
    );

    // PWM clock from clk_sys only; jitter shifts period by up to 15 cycles
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            lfsr <= 8'hA5;
        end else if (pwm_tick) begin
            lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
        end
    end

    assign pwm_limit = PWM_COUNT_WIDTH'(PWM_PERIOD - 1)
        - (pwm_jitter_enable ? PWM_COUNT_WIDTH'(lfsr[3:0]) : '0);
    assign pwm_tick = (pwm_count >= pwm_limit);

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pwm_count <= '0;
            pwm_cycle_start <= 1'b0;
        end else begin
            pwm_count <= pwm_tick ? '0 : pwm_count + 1'b1;
            pwm_cycle_start <= pwm_tick;
        end
    end

    // Setpoints latched at PWM boundary so a step lands on next cycle
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            coil_x_setpoint <= '0;
            coil_y_setpoint <= '{1'b0, SETPOINT_MAX};
        end else if (pwm_tick) begin
            coil_x_setpoint <= table_x;
            coil_y_setpoint <= table_y;
        end
    end

    // Peak current loop: on at PWM start, off when sense passes setpoint
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            coil_on <= '0;
            on_count <= '0;
        end else begin
            on_count <= pwm_tick ? '0 : on_count + 1'b1;
            if (!drive_enable) begin
                coil_on <= '0;
            end else if (pwm_tick) begin
                coil_on <= {table_y.magnitude != 7'h00, table_x.magnitude != 7'h00};
            end else if (on_count >= PWM_COUNT_WIDTH'(MIN_ON_CYCLES)) begin
                // Blanking hides the switching spike from the comparator
                if (sense_x_sync[1]) begin
                    coil_on[0] <= 1'b0;
                end
                if (sense_y_sync[1]) begin
                    coil_on[1] <= 1'b0;
                end
            end
        end
    end

    // Per bridge: sign picks diagonal; off means slow decay on low sides
    always_comb begin
        bridge_request[0] = coil_on[0] && !coil_x_setpoint.sign;
        bridge_request[1] = coil_on[0] && coil_x_setpoint.sign;
        bridge_request[2] = coil_on[1] && !coil_y_setpoint.sign;
        bridge_request[3] = coil_on[1] && coil_y_setpoint.sign;
    end

    // Half-bridges: 0 coil_x_positive, 1 coil_x_negative, 2/3 for Y
    // gate_drive[2h] is the high side, [2h+1] the low side
    genvar h;
    generate
        for (h = 0; h < 4; h++) begin : g_half
            gate_sequencer u_seq (
                .clk_sys(clk_sys),
                .arst_n(arst_n),
                .high_request(bridge_request[h]),
                .gate_config(gate_config),
                .high_drive(gate_drive[2*h]),
                .low_drive(gate_drive[2*h+1])
            );
        end
    endgenerate

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            on_current_level <= '0;
            off_current_level <= '0;
        end else begin
            on_current_level <= gate_config.on_current_select;
            off_current_level <= gate_config.off_current_select;
        end
    end

    a_clear_zero: assert property (@(posedge clk_sys) disable iff (!arst_n)
        clear_sync[1] |=> position == 8'h00)
        else $error("clear did not zero position");

    a_step_forward: assert property (@(posedge clk_sys) disable iff (!arst_n)
        step_edge && drive_enable && !clear_sync[1] && step_up
        && step_resolution_select == 3'h4 |=> position == $past(position) + 8'h10)
        else $error("quarter step forward wrong");

    a_step_reverse: assert property (@(posedge clk_sys) disable iff (!arst_n)
        step_edge && drive_enable && !clear_sync[1] && !step_up
        && step_resolution_select == 3'h0 |=> position == $past(position) - 8'h01)
        else $error("reverse step wrong");

    a_disabled_hold: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !drive_enable && !clear_sync[1] |=> $stable(position))
        else $error("position moved while disabled");

    a_full_diag: assert property (@(posedge clk_sys) disable iff (!arst_n)
        step_edge && drive_enable && !clear_sync[1] && step_resolution_select == 3'h7
        |=> position[5:0] == 6'h20)
        else $error("full step left diagonal");

    a_readback_track: assert property (@(posedge clk_sys) disable iff (!arst_n)
        ##1 position_readback == $past(position))
        else $error("readback lags position");

    a_setpoint_sync: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !pwm_cycle_start |-> $stable(coil_x_setpoint) && $stable(coil_y_setpoint))
        else $error("setpoint changed mid cycle");

    a_pwm_period: assert property (@(posedge clk_sys) disable iff (!arst_n)
        pwm_cycle_start && !pwm_jitter_enable |-> ##[1:800] pwm_cycle_start)
        else $error("pwm period too long");

    a_off_no_drive: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !drive_enable |=> coil_on == 2'b00)
        else $error("coil driven while disabled");

    a_bridge_idle: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !drive_enable |=> bridge_request == 4'h0)
        else $error("bridge requested while disabled");

    a_half_step: assert property (@(posedge clk_sys) disable iff (!arst_n)
        step_edge && drive_enable && !clear_sync[1] && step_up
        && step_resolution_select == 3'h5 |=> position == $past(position) + 8'h20)
        else $error("half step size wrong");

    a_pwm_pulse: assert property (@(posedge clk_sys) disable iff (!arst_n)
        pwm_cycle_start |=> !pwm_cycle_start)
        else $error("pwm start wider than one cycle");
endmodule : microstep_translator_pwm
`default_nettype wire

// *** tb/step_source.sv ***
`timescale 1ns/1ps
`default_nettype none
module step_source (
    input wire logic clk_sys,
    input wire logic start,
    input wire logic reverse,
    input wire logic slow,
    input wire logic [7:0] count,
    output logic step_pulse_pin,
    output logic direction_pin,
    output logic busy
);
    int width;
    initial begin
        step_pulse_pin = 1'b0;
        direction_pin = 1'b0;
        busy = 1'b0;
        forever begin
            @(negedge clk_sys);
            if (start) begin
                busy = 1'b1;
                // Prompt pulses sit at the sync minimum, slow ones above 625 ns
                width = slow ? 13 : 3;
                direction_pin = reverse;
                repeat (20) @(negedge clk_sys);
                repeat (count) begin
                    step_pulse_pin = 1'b1;
                    repeat (width) @(negedge clk_sys);
                    step_pulse_pin = 1'b0;
                    repeat (width) @(negedge clk_sys);
                end
                repeat (20) @(negedge clk_sys);
                busy = 1'b0;
            end
        end
    end
endmodule : step_source
`default_nettype wire

// *** tb/microstep_translator_pwm_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module microstep_translator_pwm_tb;
    import stepper_pkg::*;
    typedef struct packed {
        logic [2:0] res; logic rev; logic inv; logic [7:0] n;
        logic [7:0] pos; logic [7:0] x; logic [7:0] y;
    } row_type;
    logic clk_sys, arst_n, step_pulse_pin, direction_pin, clear_pin, sense_x_above;
    logic sense_y_above, drive_enable, direction_invert_bit, step_edge_polarity;
    logic pwm_jitter_enable, start, reverse, slow, busy, pwm_cycle_start;
    logic [2:0] step_resolution_select;
    logic [7:0] count, position_readback, g, ov;
    logic [3:0] on_lvl, off_lvl;
    gate_config_type gate_config;
    gate_drive_type [7:0] gate_drive;
    setpoint_type coil_x_setpoint, coil_y_setpoint;
    int fail_count = 0, n_compared = 0, k, lo, hi;
    row_type rows [10] = '{
        {3'h0, 2'h0, 8'h01, 8'h01, 8'h03, 8'h64}, {3'h1, 2'h0, 8'h01, 8'h02, 8'h05, 8'h64},
        {3'h2, 2'h0, 8'h04, 8'h10, 8'h26, 8'h5E}, {3'h3, 2'h2, 8'h01, 8'hF8, 8'h93, 8'h62},
        {3'h4, 2'h1, 8'h01, 8'hF0, 8'hA6, 8'h5E}, {3'h5, 2'h0, 8'h01, 8'h20, 8'h47, 8'h47},
        {3'h6, 2'h0, 8'h01, 8'h20, 8'h64, 8'h64}, {3'h7, 2'h0, 8'h02, 8'h60, 8'h64, 8'hE4},
        {3'h0, 2'h2, 8'h01, 8'hFF, 8'h83, 8'h64}, {3'h6, 2'h0, 8'h03, 8'h60, 8'h64, 8'hE4}};

    step_source partner (.clk_sys(clk_sys), .start(start), .reverse(reverse), .slow(slow),
        .count(count), .step_pulse_pin(step_pulse_pin), .direction_pin(direction_pin),
        .busy(busy));
    microstep_translator_pwm #(.PWM_PERIOD(100)) dut (.clk_sys(clk_sys), .arst_n(arst_n),
        .step_pulse_pin(step_pulse_pin), .direction_pin(direction_pin),
        .clear_pin(clear_pin), .sense_x_above(sense_x_above), .sense_y_above(sense_y_above),
        .step_resolution_select(step_resolution_select), .drive_enable(drive_enable),
        .direction_invert_bit(direction_invert_bit), .step_edge_polarity(step_edge_polarity),
        .pwm_jitter_enable(pwm_jitter_enable), .gate_config(gate_config),
        .position_readback(position_readback), .coil_x_setpoint(coil_x_setpoint),
        .coil_y_setpoint(coil_y_setpoint), .pwm_cycle_start(pwm_cycle_start),
        .gate_drive(gate_drive), .on_current_level(on_lvl), .off_current_level(off_lvl));

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic final_report;
        $display("compared=%0d mismatches=%0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : final_report

    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : tick

    task automatic wait_pwm(output int n);
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
        end while (pwm_cycle_start !== 1'b1 && n < 300);
        if (n >= 300) begin
            fail_count++;
            final_report();
        end
    endtask : wait_pwm

    task automatic steps(input logic r, input logic [7:0] n, input logic s);
        int t;
        reverse = r;
        count = n;
        slow = s;
        start = 1'b1;
        t = 0;
        while (busy !== 1'b1 && t < 5) begin tick(1); t++; end
        start = 1'b0;
        while (busy !== 1'b0 && t < 3000) begin tick(1); t++; end
        if (t >= 3000) begin
            fail_count++;
            final_report();
        end
    endtask : steps

    task automatic clr;
        clear_pin = 1'b1;
        tick(4);
        clear_pin = 1'b0;
        tick(4);
        chk(position_readback, 8'h00);
    endtask : clr

    initial begin
        {arst_n, clear_pin, sense_x_above, sense_y_above, drive_enable} = 5'h00;
        {direction_invert_bit, step_edge_polarity, pwm_jitter_enable} = 3'h0;
        {start, reverse, slow, count, step_resolution_select} = '0;
        gate_config = '{4'h0, 4'h0, 4'h0, 2'h0, 4'h5, 4'h6};
        tick(10);
        arst_n = 1'b1;
        tick(2);
        chk(position_readback, 8'h00);
        chk(coil_y_setpoint, 8'h64);
        chk(coil_x_setpoint, 8'h00);
        chk({on_lvl, off_lvl}, 8'h56);
        drive_enable = 1'b1;
        foreach (rows[i]) begin
            clr();
            step_resolution_select = rows[i].res;
            direction_invert_bit = rows[i].inv;
            tick(20);
            steps(rows[i].rev, rows[i].n, i[0]);
            chk(position_readback, rows[i].pos);
            wait_pwm(k);
            wait_pwm(k);
            chk(coil_x_setpoint, rows[i].x);
            chk(coil_y_setpoint, rows[i].y);
        end
        direction_invert_bit = 1'b0;
        wait_pwm(k);
        wait_pwm(k);
        chk(8'(k), 8'h64);
        pwm_jitter_enable = 1'b1;
        lo = 999;
        hi = 0;
        repeat (10) begin
            wait_pwm(k);
            if (k < lo) lo = k;
            if (k > hi) hi = k;
        end
        chk({7'h0, lo >= 85 && hi <= 100 && lo < hi}, 8'h01);
        pwm_jitter_enable = 1'b0;
        // Position 0 drives Y from positive to negative terminal, X idle
        step_resolution_select = 3'h0;
        clr();
        {g, ov} = 16'h0000;
        repeat (300) begin
            tick(1);
            for (int h = 0; h < 8; h++) g[h] = g[h] | gate_drive[h].gate_pull_up_switch;
            for (int h = 0; h < 4; h++)
                ov[h] = ov[h] | (gate_drive[2*h].gate_pull_up_switch
                    & gate_drive[2*h+1].gate_pull_up_switch);
        end
        chk(g & 8'h90, 8'h90);
        chk(ov, 8'h00);
        // Comparator above setpoint must cut the on phase short
        sense_y_above = 1'b1;
        tick(200);
        k = 0;
        repeat (300) begin tick(1); k = k + gate_drive[4].gate_pull_up_switch; end
        chk({7'h0, k < 50}, 8'h01);
        sense_y_above = 1'b0;
        drive_enable = 1'b0;
        tick(20);
        steps(1'b0, 8'h02, 1'b0);
        chk(position_readback, 8'h00);
        g = 8'h00;
        for (int h = 0; h < 8; h++) g[h] = gate_drive[h].gate_pull_up_switch;
        chk(g & 8'h55, 8'h00);
        drive_enable = 1'b1;
        step_edge_polarity = 1'b1;
        tick(20);
        fork
            steps(1'b0, 8'h01, 1'b1);
            begin
                k = 0;
                while (step_pulse_pin !== 1'b1 && k < 100) begin tick(1); k++; end
                tick(8);
                chk(position_readback, 8'h00);
            end
        join
        chk(position_readback, 8'h01);
        final_report();
    end
endmodule : microstep_translator_pwm_tb
`default_nettype wire
